/* logic/ept_core.sv */
// Page-write sequencing, write protection and array of the serial EEPROM.
// Operation
// [R1] Host sends page-write opcode, 16-bit address, then data, with chip select low.
// [R2] After the first data byte, further data bytes are accepted in sequence.
// [R3] One page-write changes at most 32 bytes, all within one page.
// [R4] Pages are aligned; the low five address bits span 0 to 31.
// [R5] After the last byte of a page the address wraps to that page's start.
// [R6] With more than 32 data bytes only the final 32 are kept.
// [R7] Block-protected locations are never written while that block setting holds.
// [R8] Unprotected locations are written only when the write latch is 1.
// [R9] Completing an array write clears the write latch.
// [R10] Host should set the write latch before every page-write.
// [R11] Hardware protection never affects array writes, only the status bits.
// [R12] Hardware protection is enable bit 1 with pin low; it freezes status bits.
// [R13] Only address bits 10 to 0 select the location; upper bits ignored.
// [R14] Page-write is 0000x010, set-latch 0000x110; bit 3 is ignored.
// [R15] Chip select rising after the last bit ends the frame and starts work.
// [R16] During a write cycle every command except read-status is ignored.
// [R17] The write latch is zero after power-up.
// [R18] A frame ending off a byte boundary is discarded entirely.
`timescale 1ns/1ps
module ept_core
   import ept_pkg::*;
#(
   parameter int unsigned WC_LEN = WC_CYCLES
)(
   input  wire logic              mclk,
   input  wire logic              arst_n,
   input  wire logic              sck,
   input  wire logic              cs_n,
   input  wire logic              si,
   input  wire logic              wp_n,
   input  wire logic [ADDR_W-1:0] rd_addr,
   output logic      [7:0]        rd_data_q,
   output logic                   wel_q,
   output logic                   busy_q,
   output logic                   protect_enable_bit_q,
   output logic                   block_protect_lo_q,
   output logic                   block_protect_hi_q,
   output logic                   hw_protect_q
);
   logic [7:0]       rx_byte;
   logic             byte_tog;
   logic             bit_tog;
   logic [3:0]       s1_q, s2_q, s3_q;
   ept_state_e       st_q, st_d;
   ept_cmd_e         cmd_q, opc_cmd;
   logic [2:0]       addr_hi_q;
   logic [5:0]       page_q;
   logic [4:0]       ptr_q;
   logic [31:0]      mask_q;
   logic             have_data_q;
   logic [7:0]       sr_new_q;
   logic             have_sr_q;
   logic [2:0]       bits_q;
   logic             end_q;
   logic [WC_W-1:0]  wc_q;
   logic [5:0]       idx_q;
   logic             wr_pend_q;
   logic             sr_pend_q;
   logic [7:0]       buf_q [0:PAGE_BYTES-1];
   logic [7:0]       mem_q [0:MEM_DEPTH-1];

   ept_spi_rx u_rx (
      .sck        (sck),
      .cs_n       (cs_n),
      .si         (si),
      .arst_n     (arst_n),
      .rx_byte_q  (rx_byte),
      .byte_tog_q (byte_tog),
      .bit_tog_q  (bit_tog)
   );

   // Pins and link toggles pass two flops; the third stage serves edge detection only.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= SYNC_RST;
         s2_q <= SYNC_RST;
         s3_q <= SYNC_RST;
      end else begin
         s1_q <= {wp_n, cs_n, byte_tog, bit_tog};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   wire       bit_ev   = s2_q[0] ^ s3_q[0];
   wire       byte_ev  = s2_q[1] ^ s3_q[1];
   wire       cs_fall  = s3_q[2] & ~s2_q[2];
   wire       cs_rise  = ~s3_q[2] & s2_q[2];
   wire       wp_pin_n = s2_q[3];
   wire [7:0] opc      = rx_byte & OPC_MASK;                                    // [R14]

   assign opc_cmd = busy_q                 ? CMD_NONE    :                      // [R16]
                    (opc == OPC_WRITE)     ? CMD_WRITE   :
                    (opc == OPC_SET_WEL)   ? CMD_SET_WEL :
                    (opc == OPC_CLR_WEL)   ? CMD_CLR_WEL :
                    (opc == OPC_WR_SR)     ? CMD_WR_SR   : CMD_NONE;

   function automatic logic in_block(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
      in_block = (bp == 2'b11) | ((bp == 2'b10) & (a >= PROT_HALF_BASE)) |
                 ((bp == 2'b01) & (a >= PROT_QTR_BASE));
   endfunction

   wire [1:0]        bp_sel   = {block_protect_hi_q, block_protect_lo_q};
   wire              hwp      = protect_enable_bit_q & ~wp_pin_n;               // [R12]
   wire              frame_ok = end_q & (bits_q == BIT_CNT_RST) & ~busy_q;      // [R18] [R16]
   wire              go_write = frame_ok & (cmd_q == CMD_WRITE) & have_data_q & wel_q; // [R8] [R11]
   wire              go_sr    = frame_ok & (cmd_q == CMD_WR_SR) & have_sr_q & wel_q & ~hwp; // [R12]
   wire              go_set   = frame_ok & (cmd_q == CMD_SET_WEL);
   wire              go_clr   = frame_ok & (cmd_q == CMD_CLR_WEL);
   wire              wc_done  = busy_q & (wc_q == '0);
   wire [ADDR_W-1:0] mem_addr = {page_q, idx_q[4:0]};                           // [R3]
   wire              commit   = busy_q & wr_pend_q & ~idx_q[5];
   wire              mem_we   = commit & mask_q[idx_q[4:0]] & ~in_block(mem_addr, bp_sel); // [R7]
   wire [2:0]        bits_now = bits_q + {2'b00, bit_ev};

   always_comb begin
      st_d = st_q;
      if (end_q) begin
         st_d = ST_IDLE;
      end else if (cs_fall) begin
         st_d = ST_OPC;
      end else if (byte_ev) begin
         unique case (st_q)
            ST_IDLE: st_d = ST_IDLE;
            ST_OPC:  st_d = (opc_cmd == CMD_WRITE) ? ST_ADH :
                            (opc_cmd == CMD_WR_SR) ? ST_STAT : ST_SKIP;        // [R16]
            ST_ADH:  st_d = ST_ADL;
            ST_ADL:  st_d = ST_DATA;
            ST_DATA: st_d = ST_DATA;                                           // [R2]
            ST_STAT: st_d = ST_SKIP;
            ST_SKIP: st_d = ST_SKIP;
            default: st_d = ST_IDLE;
         endcase
      end
   end

   // Frame decoding: opcode, address and bit alignment of the frame in progress.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_q      <= ST_IDLE;
         cmd_q     <= CMD_NONE;
         addr_hi_q <= 3'h0;
         bits_q    <= BIT_CNT_RST;
         end_q     <= 1'b0;
         sr_new_q  <= 8'h00;
         have_sr_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         end_q  <= cs_rise;                                                     // [R15]
         bits_q <= cs_fall ? BIT_CNT_RST : bits_now;
         if (cs_fall) begin
            cmd_q     <= CMD_NONE;
            have_sr_q <= 1'b0;
         end else if (byte_ev && st_q == ST_OPC) begin
            cmd_q <= opc_cmd;
         end
         if (byte_ev && st_q == ST_ADH) addr_hi_q <= rx_byte[2:0];              // [R13]
         if (byte_ev && st_q == ST_STAT) begin
            sr_new_q  <= rx_byte;
            have_sr_q <= 1'b1;
         end
      end
   end

   // Page buffer control: the pointer wraps inside the page, so later bytes overwrite earlier.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         page_q      <= 6'h00;
         ptr_q       <= 5'h00;
         mask_q      <= 32'h0000_0000;
         have_data_q <= 1'b0;
      end else if (cs_fall && !busy_q) begin
         mask_q      <= 32'h0000_0000;
         have_data_q <= 1'b0;
      end else if (byte_ev && st_q == ST_ADL) begin
         page_q <= {addr_hi_q, rx_byte[7:5]};                                   // [R4]
         ptr_q  <= rx_byte[4:0];
      end else if (byte_ev && st_q == ST_DATA) begin
         mask_q[ptr_q] <= 1'b1;                                                 // [R6]
         ptr_q         <= ptr_q + 5'h01;                                        // [R5]
         have_data_q   <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (byte_ev && st_q == ST_DATA) buf_q[ptr_q] <= rx_byte;                  // [R6]
      if (mem_we) mem_q[mem_addr] <= buf_q[idx_q[4:0]];                         // [R3]
   end

   // Write cycle, write latch and status bits.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wel_q                <= WEL_RST;                                       // [R17]
         busy_q               <= 1'b0;
         wc_q                 <= '0;
         idx_q                <= 6'h00;
         wr_pend_q            <= 1'b0;
         sr_pend_q            <= 1'b0;
         protect_enable_bit_q <= PE_RST;
         block_protect_lo_q   <= BP_RST;
         block_protect_hi_q   <= BP_RST;
         hw_protect_q         <= 1'b0;
         rd_data_q            <= 8'h00;
      end else begin
         hw_protect_q <= hwp;
         rd_data_q    <= mem_q[rd_addr];
         if (go_write || go_sr) begin
            busy_q    <= 1'b1;
            wc_q      <= WC_W'(WC_LEN - 1);
            idx_q     <= 6'h00;
            wr_pend_q <= go_write;
            sr_pend_q <= go_sr;
         end else if (wc_done) begin
            busy_q    <= 1'b0;
            wel_q     <= 1'b0;                                                  // [R9]
            wr_pend_q <= 1'b0;
            sr_pend_q <= 1'b0;
            if (sr_pend_q) begin
               protect_enable_bit_q <= sr_new_q[SR_PE_POS];                     // [R12]
               block_protect_hi_q   <= sr_new_q[SR_BP_HI_POS];
               block_protect_lo_q   <= sr_new_q[SR_BP_LO_POS];
            end
         end else if (busy_q) begin
            wc_q <= wc_q - WC_W'(1);
            if (!idx_q[5]) idx_q <= idx_q + 6'h01;
         end else if (go_set) begin
            wel_q <= 1'b1;
         end else if (go_clr) begin
            wel_q <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   wel_clear_a: assert property ($fell(busy_q) |-> !wel_q)                     // [R9]
      else $error("write latch still set after write cycle");
   start_needs_wel_a: assert property ($rose(busy_q) |-> $past(wel_q))          // [R8]
      else $error("write cycle started without write latch");
   write_busy_a: assert property (mem_we |-> busy_q && wr_pend_q)               // [R8]
      else $error("array written outside a write cycle");
   block_guard_a: assert property (mem_we |-> !in_block(mem_addr, bp_sel))      // [R7]
      else $error("protected location written");
   page_wrap_a: assert property (st_q == ST_DATA && byte_ev && !end_q && !cs_fall
      && ptr_q == 5'h1f |=> ptr_q == 5'h00 && page_q == $past(page_q))        // [R5]
      else $error("pointer left its page");
   busy_ignore_a: assert property (busy_q && st_q == ST_OPC && byte_ev
      && !end_q && !cs_fall |=> st_q == ST_SKIP)                                // [R16]
      else $error("command accepted during write cycle");
   partial_drop_a: assert property (end_q && !busy_q && bits_q != BIT_CNT_RST
      |=> !busy_q && wel_q == $past(wel_q))                                     // [R18]
      else $error("partial frame acted upon");
   status_lock_a: assert property (end_q && !busy_q && hwp && cmd_q == CMD_WR_SR
      |=> !busy_q)                                                              // [R12]
      else $error("status write accepted under hardware protection");
   commit_span_a: assert property ($rose(busy_q) && wr_pend_q |-> commit [*8])  // [R3]
      else $error("page commit interrupted");

   write_start_c: cover property ($rose(busy_q) && wr_pend_q);
   page_wrap_c: cover property (st_q == ST_DATA && byte_ev && ptr_q == 5'h1f);
   status_write_c: cover property ($rose(busy_q) && sr_pend_q);
   partial_frame_c: cover property (end_q && bits_q != BIT_CNT_RST);
endmodule

/* logic/ept_pkg.sv */
// Constants and types shared by the page-write and protection logic.
package ept_pkg;
   localparam int unsigned CLK_HZ       = 40_000_000;
   localparam int unsigned T_WC_MS      = 5;
   localparam int unsigned WC_CYCLES    = T_WC_MS * (CLK_HZ / 1000);
   localparam int unsigned WC_W         = 18;
   localparam int unsigned ADDR_W       = 11;
   localparam int unsigned MEM_DEPTH    = 2048;
   localparam int unsigned PAGE_W       = 5;
   localparam int unsigned PAGE_BYTES   = 32;
   localparam logic [7:0]  OPC_MASK     = 8'hf7;
   localparam logic [7:0]  OPC_WRITE    = 8'h02;
   localparam logic [7:0]  OPC_SET_WEL  = 8'h06;
   localparam logic [7:0]  OPC_CLR_WEL  = 8'h04;
   localparam logic [7:0]  OPC_WR_SR    = 8'h01;
   localparam logic [7:0]  OPC_RD_SR    = 8'h05;
   localparam int unsigned SR_PE_POS    = 7;
   localparam int unsigned SR_BP_HI_POS = 3;
   localparam int unsigned SR_BP_LO_POS = 2;
   localparam logic [10:0] PROT_QTR_BASE  = 11'h600;
   localparam logic [10:0] PROT_HALF_BASE = 11'h400;
   localparam logic        WEL_RST      = 1'b0;
   localparam logic        PE_RST       = 1'b0;
   localparam logic        BP_RST       = 1'b0;
   localparam logic [2:0]  BIT_CNT_RST  = 3'h0;
   localparam logic [2:0]  BYTE_LAST    = 3'h7;
   localparam logic [3:0]  SYNC_RST     = 4'hc;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_OPC  = 3'b001,
      ST_ADH  = 3'b010,
      ST_ADL  = 3'b011,
      ST_DATA = 3'b100,
      ST_STAT = 3'b101,
      ST_SKIP = 3'b110
   } ept_state_e;

   typedef enum logic [2:0] {
      CMD_NONE    = 3'b000,
      CMD_WRITE   = 3'b001,
      CMD_SET_WEL = 3'b010,
      CMD_CLR_WEL = 3'b011,
      CMD_WR_SR   = 3'b100
   } ept_cmd_e;
endpackage

/* logic/ept_spi_rx.sv */
// Serial shifter on the link clock that assembles bytes and flags each bit and byte.
`timescale 1ns/1ps
module ept_spi_rx
   import ept_pkg::*;
(
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic       si,
   input  wire logic       arst_n,
   output logic      [7:0] rx_byte_q,
   output logic            byte_tog_q,
   output logic            bit_tog_q
);
   logic [6:0] shift_q;
   logic [2:0] cnt_q;
   wire        frame_rst_n = arst_n & ~cs_n;

   // The bit count restarts whenever chip select is high, so every frame begins byte aligned.
   always_ff @(posedge sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         shift_q <= 7'h00;
         cnt_q   <= BIT_CNT_RST;
      end else begin
         shift_q <= {shift_q[5:0], si};
         cnt_q   <= cnt_q + 3'h1;
      end
   end

   // The toggles survive the frame end, so the core never sees a false event.
   always_ff @(posedge sck or negedge arst_n) begin
      if (!arst_n) begin
         rx_byte_q  <= 8'h00;
         byte_tog_q <= 1'b0;
         bit_tog_q  <= 1'b0;
      end else if (!cs_n) begin
         bit_tog_q <= ~bit_tog_q;
         if (cnt_q == BYTE_LAST) begin
            rx_byte_q  <= {shift_q, si};
            byte_tog_q <= ~byte_tog_q;
         end
      end
   end
endmodule

/* test/ept_spi_host.sv */
// SPI host model that sends frames to the device at a 125 ns serial period.
`timescale 1ns/1ps
module ept_spi_host (
   output logic sck,
   output logic cs_n,
   output logic si
);
   logic [7:0] q[$];

   initial begin
      sck  = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end

   // Sends nbits of the queued bytes MSB first; sck stands low outside frames.
   task automatic send(input int nbits);
      logic [7:0] b;
      cs_n = 1'b0;
      // The odd setup delay keeps the serial edges away from the system clock edges.
      #67.3;
      for (int i = 0; i < nbits; i++) begin
         b   = q[i / 8];
         si  = b[7 - (i % 8)];
         #62.5;
         sck = 1'b1;
         #62.5;
         sck = 1'b0;
      end
      // A released data line shows the inverse of its last value.
      si   = ~si;
      #62.5;
      cs_n = 1'b1;
      q.delete();
      #500;
   endtask
endmodule

/* test/tb_ept_core.sv */
// Self-checking bench for the page-write and protection logic.
`timescale 1ns/1ps
module tb_ept_core;
   import ept_pkg::*;
   localparam int unsigned WC = 200;
   logic              mclk;
   logic              arst_n;
   logic              wp_n;
   logic [ADDR_W-1:0] rd_addr;
   logic              sck;
   logic              cs_n;
   logic              si;
   logic [7:0]        rd_data_q;
   logic              wel_q;
   logic              busy_q;
   logic              pe_q;
   logic              bp_lo_q;
   logic              bp_hi_q;
   logic              hw_q;
   int                num_errors = 0;
   int                compares   = 0;
   int                cycles     = 0;

   ept_spi_host host (
      .sck  (sck),
      .cs_n (cs_n),
      .si   (si)
   );
   ept_core #(
      .WC_LEN (WC)
   ) DUT (
      .mclk                 (mclk),
      .arst_n               (arst_n),
      .sck                  (sck),
      .cs_n                 (cs_n),
      .si                   (si),
      .wp_n                 (wp_n),
      .rd_addr              (rd_addr),
      .rd_data_q            (rd_data_q),
      .wel_q                (wel_q),
      .busy_q               (busy_q),
      .protect_enable_bit_q (pe_q),
      .block_protect_lo_q   (bp_lo_q),
      .block_protect_hi_q   (bp_hi_q),
      .hw_protect_q         (hw_q)
   );

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         conclude();
      end
   end

   task automatic conclude;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wait_idle;
      int k;
      k = 0;
      while (busy_q !== 1'b0 && k < 1000) begin
         @(posedge mclk);
         k++;
      end
      if (k == 1000) begin
         num_errors++;
         conclude();
      end
      @(posedge mclk);
      #1;
   endtask

   task automatic tx(input int nbits);
      host.send(nbits);
      wait_idle();
   endtask

   task automatic set_wel;
      host.q.push_back(OPC_SET_WEL);
      tx(8);
      chk("wel after set", 8'h01, {7'h00, wel_q});
   endtask

   task automatic wr(input logic [7:0] opc, input logic [15:0] a, input int nd,
                     input logic [7:0] d0);
      host.q.push_back(opc);
      host.q.push_back(a[15:8]);
      host.q.push_back(a[7:0]);
      for (int i = 0; i < nd; i++)
         host.q.push_back(8'(d0 + i));
      tx(24 + 8 * nd);
   endtask

   task automatic wrsr(input logic [7:0] v);
      host.q.push_back(OPC_WR_SR);
      host.q.push_back(v);
      tx(16);
   endtask

   task automatic rd(input logic [10:0] a, input logic [7:0] exp, input string what);
      @(posedge mclk);
      rd_addr <= a;
      @(posedge mclk);
      @(posedge mclk);
      #1;
      chk(what, exp, rd_data_q);
   endtask

   task automatic t_reset;
      chk("wel at reset", 8'h00, {7'h00, wel_q});
      chk("busy at reset", 8'h00, {7'h00, busy_q});
      chk("status at reset", 8'h00, {5'h00, pe_q, bp_hi_q, bp_lo_q});
   endtask

   // Forty bytes from offset 3, opcode bit 3 set and upper address bits set.
   task automatic t_wrap;
      int n;
      set_wel();
      wr(OPC_WRITE | 8'h08, 16'hf8a3, 40, 8'h40);
      chk("wel after write", 8'h00, {7'h00, wel_q});
      for (int o = 0; o < 32; o++) begin
         n = (o + 29) % 32;
         if (n < 8)
            n = n + 32;
         rd(11'(11'h0a0 + o), 8'(8'h40 + n), "page byte");
      end
   endtask

   task automatic t_nolatch;
      wr(OPC_WRITE, 16'h00a3, 1, 8'h11);
      rd(11'h0a3, 8'h60, "write without latch");
   endtask

   task automatic t_trunc;
      set_wel();
      host.q.push_back(OPC_WRITE);
      host.q.push_back(8'h00);
      host.q.push_back(8'ha4);
      host.q.push_back(8'h22);
      host.q.push_back(8'h33);
      tx(38);
      chk("wel after short frame", 8'h01, {7'h00, wel_q});
      rd(11'h0a4, 8'h61, "short frame byte");
   endtask

   // A clear-latch frame sent during the write cycle must be ignored.
   task automatic t_busy;
      host.q.push_back(OPC_WRITE);
      host.q.push_back(8'h00);
      host.q.push_back(8'ha4);
      host.q.push_back(8'h77);
      host.send(32);
      chk("busy during write", 8'h01, {7'h00, busy_q});
      host.q.push_back(OPC_CLR_WEL);
      host.send(8);
      chk("wel during write", 8'h01, {7'h00, wel_q});
      chk("busy after clear frame", 8'h01, {7'h00, busy_q});
      wait_idle();
      chk("wel after write cycle", 8'h00, {7'h00, wel_q});
      rd(11'h0a4, 8'h77, "single byte");
      set_wel();
      host.q.push_back(OPC_CLR_WEL);
      tx(8);
      chk("wel after clear", 8'h00, {7'h00, wel_q});
   endtask

   task automatic t_prot;
      set_wel();
      wr(OPC_WRITE, 16'h0600, 1, 8'h5a);
      set_wel();
      wrsr(8'h84);
      chk("status written", 8'h05, {5'h00, pe_q, bp_hi_q, bp_lo_q});
      set_wel();
      wr(OPC_WRITE, 16'h0600, 1, 8'ha5);
      rd(11'h600, 8'h5a, "protected byte");
      @(posedge mclk);
      wp_n <= 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      chk("hw protect", 8'h01, {7'h00, hw_q});
      set_wel();
      wrsr(8'h00);
      chk("status frozen", 8'h05, {5'h00, pe_q, bp_hi_q, bp_lo_q});
      wr(OPC_WRITE, 16'h0100, 1, 8'h3c);
      rd(11'h100, 8'h3c, "array under hw protect");
      @(posedge mclk);
      wp_n <= 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      chk("hw protect released", 8'h00, {7'h00, hw_q});
      set_wel();
      wrsr(8'h00);
      chk("status cleared", 8'h00, {5'h00, pe_q, bp_hi_q, bp_lo_q});
   endtask

   // A reset in mid-run drops the latch, and the link works again afterwards.
   task automatic t_rst_mid;
      set_wel();
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      chk("wel after second reset", 8'h00, {7'h00, wel_q});
      chk("busy after second reset", 8'h00, {7'h00, busy_q});
      set_wel();
   endtask

   initial begin
      arst_n  = 1'b0;
      wp_n    = 1'b1;
      rd_addr = '0;
      repeat (8) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      t_reset();
      t_wrap();
      t_nolatch();
      t_trunc();
      t_busy();
      t_prot();
      t_rst_mid();
      conclude();
   end
endmodule
